// [logic/can_integ_ctrl.sv]
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "can_integ_map.svh"
module can_integ_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic can_rx_i,
  output logic can_tx_o,
  input wire logic exception_i,
  input wire logic frame_end_i,
  input wire logic frame_tx_i,
  input wire logic crc_check_i,
  input wire logic crc_fd_i,
  input wire logic [16:0] crc_rx_i,
  output logic irq_o,
  output logic sof_o,
  output logic sample_o,
  output logic rx_bit_o
);
  // ==================================================
  // Functions
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel, input logic [31:0] wmask);
    logic [31:0] bm;
    bm = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wmask;
    return (old & ~bm) | (nw & bm);
  endfunction

  function automatic logic [16:0] crc_next(input logic [16:0] c, input logic b,
                                           input logic [16:0] poly, input logic [16:0] top);
    logic fb;
    logic [16:0] msk;
    fb = b ^ (|(c & top));
    msk = (top << 1) - 17'h00001;
    return ((c << 1) & msk) ^ (fb ? poly : 17'h00000);
  endfunction

  // ==================================================
  // Declarations
  can_integ_pkg::bus_state_e state_q, state_d;
  logic [31:0] ctrl_q, tim_q, rd_data, mask_m;
  logic [3:0] cnt_q, cnt_d;
  logic [16:0] crc_fd_q, crc_cl_q;
  logic [`IRQ_W-1:0] st_q, st_d, mask_q, mask_d, ev;
  logic pend_q, fp_q, fp_d, tx_q, tx_d, sof_q, sof_d, ack_q, irq_q, smp_q, rxb_q;
  logic acc, wr, rd, wr_ctrl, wr_tim, wr_mask, rd_stat;
  logic smp, bs, rxb, ef_on, hsync_ok, start_tx, ev_integ, ev_err, crc_bad;
  logic init_hold, edge_filter_enable, protocol_exception_disable, first_id_bit;
  logic [7:0] presc, seg1, nominal_phase_seg2_length;
  logic [6:0] nominal_phase_seg2_field;

  // ==================================================
  // Wishbone decode; one wait state, ack is registered
  assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = acc & wb_we_i;
  assign rd = acc & ~wb_we_i;
  assign wr_ctrl = wr & (wb_adr_i == `REG_CTRL);
  assign wr_tim = wr & (wb_adr_i == `REG_TIMING);
  assign wr_mask = wr & (wb_adr_i == `REG_IRQ_MASK);
  assign rd_stat = rd & (wb_adr_i == `REG_IRQ_STAT);

  // Register field views
  assign init_hold = ctrl_q[`CTRL_INIT];
  assign edge_filter_enable = ctrl_q[`CTRL_EF];
  assign protocol_exception_disable = ctrl_q[`CTRL_PXD];
  assign first_id_bit = ctrl_q[`CTRL_FIRST_ID];
  assign presc = tim_q[`TIM_PRESC_LSB +: 8];
  assign seg1 = tim_q[`TIM_SEG1_LSB +: 8];
  assign nominal_phase_seg2_field = tim_q[`TIM_SEG2_LSB +: 7];
  assign nominal_phase_seg2_length = {1'b0, nominal_phase_seg2_field} + 8'h01; // [R13]

  // Read mux; unmapped offsets read zero
  assign rd_data = (wb_adr_i == `REG_CTRL) ? (ctrl_q | ({31'h0, pend_q} << `CTRL_TXREQ)) :
                   (wb_adr_i == `REG_TIMING) ? tim_q :
                   (wb_adr_i == `REG_STATE) ? {20'h0, cnt_q, 3'h0, rxb_q, 1'b0, state_q} :
                   (wb_adr_i == `REG_IRQ_STAT) ? {27'h0, st_q} :
                   (wb_adr_i == `REG_IRQ_MASK) ? {27'h0, mask_q} : 32'h0000_0000;

  // Filter runs only in integration, never during frames
  assign ef_on = edge_filter_enable & (state_q == can_integ_pkg::S_INTEG); // [R1] [R3]
  // Hard sync allowed only outside frames
  assign hsync_ok = (state_q == can_integ_pkg::S_INTEG) | (state_q == can_integ_pkg::S_IDLE) |
                    (state_q == can_integ_pkg::S_INTERM) | (state_q == can_integ_pkg::S_RECOV);

  // Compare against FD or classical register
  assign crc_bad = crc_check_i & (state_q == can_integ_pkg::S_FRAME) &
                   (crc_fd_i ? (crc_rx_i != crc_fd_q) : (crc_rx_i[14:0] != crc_cl_q[14:0])); // [R8]

  // ==================================================
  // Bit timing and receive filtering
  can_bit_clock u_bit_clock (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rx_pin_i(can_rx_i),
    .ef_on_i(ef_on),
    .hsync_ok_i(hsync_ok),
    .presc_i(presc),
    .seg1_i(seg1),
    .seg2_len_i(nominal_phase_seg2_length),
    .sample_o(smp),
    .bit_start_o(bs),
    .rx_o(rxb)
  );

  // ==================================================
  // Bus state machine
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    tx_d = tx_q;
    fp_d = fp_q;
    sof_d = 1'b0;
    start_tx = 1'b0;
    ev_integ = 1'b0;
    ev_err = 1'b0;
    case (state_q)
      can_integ_pkg::S_INIT: begin
        state_d = can_integ_pkg::S_INTEG; // [R5]
        cnt_d = 4'h0;
      end
      can_integ_pkg::S_INTEG, can_integ_pkg::S_RECOV: begin
        // Mid-frame start simply waits for ack-to-SOF recessive run
        if (smp) begin
          if (!rxb) begin
            cnt_d = 4'h0; // [R4] [R6]
          end else if (cnt_q == `INTEG_LAST) begin
            state_d = can_integ_pkg::S_IDLE; // [R2]
            ev_integ = (state_q == can_integ_pkg::S_INTEG);
            cnt_d = 4'h0;
          end else begin
            cnt_d = cnt_q + 4'h1;
          end
        end
      end
      can_integ_pkg::S_IDLE: begin
        if (smp && !rxb) begin
          state_d = can_integ_pkg::S_FRAME;
          sof_d = 1'b1;
        end else if (pend_q && bs) begin
          state_d = can_integ_pkg::S_FRAME;
          tx_d = 1'b0;
          fp_d = 1'b1;
          sof_d = 1'b1;
          start_tx = 1'b1;
        end
      end
      can_integ_pkg::S_FRAME: begin
        if (bs) begin
          tx_d = fp_q ? first_id_bit : frame_tx_i; // [R10]
          fp_d = 1'b0;
        end
        if (crc_bad) begin
          state_d = can_integ_pkg::S_ERRFLAG; // [R8]
          cnt_d = 4'h0;
          ev_err = 1'b1;
        end else if (frame_end_i) begin
          state_d = can_integ_pkg::S_INTERM;
          cnt_d = 4'h0;
          tx_d = 1'b1;
        end
      end
      can_integ_pkg::S_INTERM: begin
        if (smp) begin
          if (!rxb) begin
            // Dominant intermission bit counts as a start of frame
            state_d = can_integ_pkg::S_FRAME;
            sof_d = 1'b1;
            if (cnt_q == `INTERM_LAST && pend_q) begin
              fp_d = 1'b1; // [R9]
              start_tx = 1'b1;
            end
          end else if (cnt_q == `INTERM_LAST) begin
            state_d = can_integ_pkg::S_IDLE;
          end else begin
            cnt_d = cnt_q + 4'h1;
          end
        end
      end
      can_integ_pkg::S_ERRFLAG: begin
        if (bs) begin
          if (cnt_q == `ERRFLAG_BITS) begin
            tx_d = 1'b1;
            state_d = can_integ_pkg::S_RECOV;
            cnt_d = 4'h0;
          end else begin
            tx_d = 1'b0;
            cnt_d = cnt_q + 4'h1;
          end
        end
      end
      default: begin
        state_d = can_integ_pkg::S_INIT;
      end
    endcase
    // Exception handling overrides the frame logic
    if (!init_hold && exception_i) begin
      cnt_d = 4'h0;
      if (!protocol_exception_disable) begin
        state_d = can_integ_pkg::S_INTEG; // [R5]
        tx_d = 1'b1;
      end else begin
        state_d = can_integ_pkg::S_ERRFLAG;
      end
    end
    if (init_hold) begin
      state_d = can_integ_pkg::S_INIT;
      tx_d = 1'b1;
      fp_d = 1'b0;
    end
  end

  // Events; a zero seg2 field write is flagged as misconfigured
  assign ev = {wr_tim & wb_sel_i[2] & (wb_dat_i[`TIM_SEG2_LSB +: 7] == 7'h00), // [R11]
               exception_i & ~init_hold, start_tx, ev_err, ev_integ};
  // Sticky status: read clears, a same-cycle event still wins
  assign st_d = (st_q & ~(rd_stat ? st_q : {`IRQ_W{1'b0}})) | ev;
  assign mask_m = merge({27'h0, mask_q}, wb_dat_i, wb_sel_i, `IRQ_WMASK);
  assign mask_d = wr_mask ? mask_m[`IRQ_W-1:0] : mask_q;

  // State registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= can_integ_pkg::S_INIT;
      cnt_q <= 4'h0;
      tx_q <= 1'b1;
      fp_q <= 1'b0;
      sof_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      tx_q <= tx_d;
      fp_q <= fp_d;
      sof_q <= sof_d;
    end
  end

  // CRC registers: both restart at every start of frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crc_fd_q <= `CRC17_INIT;
      crc_cl_q <= `CRC15_INIT;
    end else if (sof_d) begin
      crc_fd_q <= `CRC17_INIT; // [R7]
      crc_cl_q <= `CRC15_INIT;
    end else if (smp && state_q == can_integ_pkg::S_FRAME) begin
      crc_fd_q <= crc_next(crc_fd_q, rxb, `CRC17_POLY, `CRC17_TOP);
      crc_cl_q <= crc_next(crc_cl_q, rxb, `CRC15_POLY, `CRC15_TOP);
    end
  end

  // Software registers; transmit request set wins over its clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `CTRL_RESET;
      tim_q <= `TIM_RESET;
      pend_q <= 1'b0;
      st_q <= {`IRQ_W{1'b0}};
      mask_q <= {`IRQ_W{1'b0}};
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i, `CTRL_WMASK);
      end
      if (wr_tim) begin
        tim_q <= merge(tim_q, wb_dat_i, wb_sel_i, `TIM_WMASK);
      end
      pend_q <= (pend_q & ~start_tx) | (wr_ctrl & wb_sel_i[0] & wb_dat_i[`CTRL_TXREQ]);
      st_q <= st_d;
      mask_q <= mask_d;
    end
  end

  // Bus answer and registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      irq_q <= 1'b0;
      smp_q <= 1'b0;
      rxb_q <= 1'b1;
    end else begin
      ack_q <= acc;
      wb_dat_o <= rd ? rd_data : 32'h0000_0000;
      irq_q <= |(st_d & mask_d);
      smp_q <= smp;
      rxb_q <= rxb;
    end
  end

  assign wb_ack_o = ack_q;
  assign irq_o = irq_q;
  assign can_tx_o = tx_q;
  assign sof_o = sof_q;
  assign sample_o = smp_q;
  assign rx_bit_o = rxb_q;

  // ==================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_last_recessive;
    state_q == can_integ_pkg::S_INTEG && !init_hold && !exception_i && smp && rxb && cnt_q == `INTEG_LAST;
  endsequence

  property p_integ_end;
    s_last_recessive |=> state_q == can_integ_pkg::S_IDLE ##0 st_q[`IRQ_INTEG];
  endproperty
  a_integ_end: assert property (p_integ_end) else $error("integration did not end on eleventh bit"); // [R2]

  property p_ef_only_integ;
    ef_on |-> state_q == can_integ_pkg::S_INTEG;
  endproperty
  a_ef_only_integ: assert property (p_ef_only_integ) else $error("edge filter active outside integration"); // [R3]

  property p_ef_on;
    state_q == can_integ_pkg::S_INTEG && edge_filter_enable |-> ef_on;
  endproperty
  a_ef_on: assert property (p_ef_on) else $error("edge filter not applied while integrating"); // [R1]

  property p_restart;
    state_q == can_integ_pkg::S_INTEG && !init_hold && !exception_i && smp && !rxb |=> cnt_q == 4'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("idle count not restarted on dominant"); // [R4]

  property p_init_release;
    state_q == can_integ_pkg::S_INIT && !init_hold && !exception_i |=> state_q == can_integ_pkg::S_INTEG;
  endproperty
  a_init_release: assert property (p_init_release) else $error("init release did not integrate"); // [R5]

  property p_exception;
    exception_i && !init_hold |=> state_q == (protocol_exception_disable ? can_integ_pkg::S_ERRFLAG
                                                                          : can_integ_pkg::S_INTEG);
  endproperty
  a_exception: assert property (p_exception) else $error("exception took the wrong path"); // [R5]

  property p_sof_crc;
    sof_q |-> crc_fd_q == `CRC17_INIT && crc_cl_q == `CRC15_INIT;
  endproperty
  a_sof_crc: assert property (p_sof_crc) else $error("CRC not reset at start of frame"); // [R7]

  property p_crc_err;
    crc_bad && !init_hold && !exception_i |=> state_q == can_integ_pkg::S_ERRFLAG ##0 st_q[`IRQ_CRC];
  endproperty
  a_crc_err: assert property (p_crc_err) else $error("CRC mismatch without error frame"); // [R8]

  sequence s_third_dominant;
    state_q == can_integ_pkg::S_INTERM && !init_hold && !exception_i && smp && !rxb &&
      cnt_q == `INTERM_LAST && pend_q;
  endsequence

  property p_interm_tx;
    s_third_dominant |=> state_q == can_integ_pkg::S_FRAME && sof_q && fp_q && !pend_q;
  endproperty
  a_interm_tx: assert property (p_interm_tx) else $error("pending send not started on third bit"); // [R9]

  property p_first_id;
    state_q == can_integ_pkg::S_FRAME && fp_q && bs && !init_hold && !exception_i |=> can_tx_o == first_id_bit;
  endproperty
  a_first_id: assert property (p_first_id) else $error("first identifier bit level wrong"); // [R10]

  property p_cfg_zero;
    wr_tim && wb_sel_i[2] && wb_dat_i[`TIM_SEG2_LSB +: 7] == 7'h00 |=> st_q[`IRQ_CFG];
  endproperty
  a_cfg_zero: assert property (p_cfg_zero) else $error("zero seg2 field not flagged"); // [R11]
endmodule

// [logic/can_integ_map.svh]
// Functional notes
// R1: Edge filter enable delays receive into timing.
// R2: Integration ends at eleventh recessive sample.
// R3: Edge filter only active while integrating.
// R4: Idle count restarts after two dominant quanta.
// R5: Integrate on init release or allowed exception.
// R6: Mid-frame integration counts ack-to-SOF recessive bits.
// R7: FD CRC reset per frame, classical separate.
// R8: FD CRC mismatch sends error frame.
// R9: Pending transmit starts on dominant third intermission.
// R10: First identifier bit follows stored buffer level.
// R11: Phase segment 2 field programmed 1..127.
// R12: Standard glitch filter independent of edge filter.
// R13: Phase segment 2 length is field plus one.
`ifndef CAN_INTEG_MAP_SVH
`define CAN_INTEG_MAP_SVH

// ==================================================
// Register offsets
`define REG_CTRL 8'h00
`define REG_TIMING 8'h04
`define REG_STATE 8'h08
`define REG_IRQ_STAT 8'h0c
`define REG_IRQ_MASK 8'h10

// ==================================================
// Control and timing fields and reset values
`define CTRL_INIT 0
`define CTRL_EF 1
`define CTRL_PXD 2
`define CTRL_TXREQ 3
`define CTRL_FIRST_ID 4
`define CTRL_WMASK 32'h0000_0017
`define CTRL_RESET 32'h0000_0001
`define TIM_PRESC_LSB 0
`define TIM_SEG1_LSB 8
`define TIM_SEG2_LSB 16
`define TIM_WMASK 32'h007f_ffff
`define TIM_RESET 32'h0007_0e03

// ==================================================
// Bit counts
`define INTEG_LAST 4'ha
`define INTERM_LAST 4'h2
`define ERRFLAG_BITS 4'h6

// ==================================================
// CRC shapes
`define CRC15_POLY 17'h04599
`define CRC15_TOP 17'h04000
`define CRC15_INIT 17'h00000
`define CRC17_POLY 17'h1685b
`define CRC17_TOP 17'h10000
`define CRC17_INIT 17'h10000

// ==================================================
// Interrupt status bits
`define IRQ_INTEG 0
`define IRQ_CRC 1
`define IRQ_TXSTART 2
`define IRQ_EXC 3
`define IRQ_CFG 4
`define IRQ_W 5
`define IRQ_WMASK 32'h0000_001f

`endif

// [logic/can_integ_pkg.sv]
package can_integ_pkg;
  // Bus integration states
  typedef enum logic [2:0] {
    S_INIT,
    S_INTEG,
    S_IDLE,
    S_FRAME,
    S_INTERM,
    S_ERRFLAG,
    S_RECOV
  } bus_state_e;
endpackage

// [logic/can_bit_clock.sv]
`timescale 1ns/1ps
`include "can_integ_map.svh"
module can_bit_clock (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_pin_i,
  input wire logic ef_on_i,
  input wire logic hsync_ok_i,
  input wire logic [7:0] presc_i,
  input wire logic [7:0] seg1_i,
  input wire logic [7:0] seg2_len_i,
  output logic sample_o,
  output logic bit_start_o,
  output logic rx_o
);
  logic s1_q, s2_q, s3_q, rx_g_q, dom_q, rx_f_q, rx_f_prev_q;
  logic [7:0] presc_cnt_q;
  logic [8:0] tq_cnt_q;
  logic tq, bit_end, fall, rx_f_d;
  logic [8:0] bit_last;

  // ==================================================
  // Quantum and bit position decode
  assign tq = (presc_cnt_q == presc_i);
  assign bit_last = {1'b0, seg1_i} + {1'b0, seg2_len_i}; // [R13]
  assign bit_end = tq & (tq_cnt_q == bit_last);
  assign fall = rx_f_prev_q & ~rx_f_q;
  // Dominant passes only after two dominant quanta in a row
  assign rx_f_d = !ef_on_i ? rx_g_q : (!tq ? rx_f_q : (rx_g_q ? 1'b1 : (dom_q ? 1'b0 : rx_f_q))); // [R1] [R4]
  assign sample_o = tq & (tq_cnt_q == {1'b0, seg1_i});
  assign bit_start_o = bit_end;
  assign rx_o = rx_f_q;

  // Pin synchroniser and glitch filter; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      rx_g_q <= 1'b1;
    end else begin
      s1_q <= rx_pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        rx_g_q <= s2_q; // [R12]
      end
    end
  end

  // Edge filter state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dom_q <= 1'b0;
      rx_f_q <= 1'b1;
      rx_f_prev_q <= 1'b1;
    end else begin
      if (tq) begin
        dom_q <= ~rx_g_q;
      end
      rx_f_q <= rx_f_d;
      rx_f_prev_q <= rx_f_q;
    end
  end

  // Prescaler and quantum counter; hard sync restarts the bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_cnt_q <= 8'h00;
      tq_cnt_q <= 9'h000;
    end else if (fall && hsync_ok_i) begin
      presc_cnt_q <= 8'h00;
      tq_cnt_q <= 9'h000;
    end else if (tq) begin
      presc_cnt_q <= 8'h00;
      tq_cnt_q <= bit_end ? 9'h000 : tq_cnt_q + 9'h001;
    end else begin
      presc_cnt_q <= presc_cnt_q + 8'h01;
    end
  end

  // ==================================================
  // Checks
  property p_glitch;
    @(posedge clk_i) disable iff (rst_i)
    $changed(rx_g_q) |-> $past(s2_q) == $past(s3_q);
  endproperty
  a_glitch: assert property (p_glitch) else $error("filtered rx moved on unstable input"); // [R12]

  property p_spike;
    @(posedge clk_i) disable iff (rst_i)
    ef_on_i && rx_f_q && !rx_f_d |-> tq && dom_q && !rx_g_q;
  endproperty
  a_spike: assert property (p_spike) else $error("edge filter passed a one quantum spike"); // [R4]

  property p_bitlen;
    @(posedge clk_i) disable iff (rst_i)
    bit_start_o |=> tq_cnt_q == 9'h000;
  endproperty
  a_bitlen: assert property (p_bitlen) else $error("bit did not wrap at seg1 plus seg2"); // [R13]
endmodule

// [dv/can_peer.sv]
`timescale 1ns/1ps
// ==================================================
// Other node on the shared bus
module can_peer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dut_tx_i,
  input wire logic dom_i,
  output logic bus_o
);
  logic dom_q;

  // Own drive is registered like a transceiver, so it lands just after an edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dom_q <= 1'b0;
    end else begin
      dom_q <= dom_i;
    end
  end

  // Wired-AND bus; the pull-up leaves a released bus recessive
  assign bus_o = dut_tx_i & ~dom_q;
endmodule

// [dv/can_integ_ctrl_bench.sv]
`timescale 1ns/1ps
// ==================================================
// Bench: integration, edge filter, intermission start
module can_integ_ctrl_bench;
  localparam logic [31:0] TIM_VAL = 32'h0002_0401;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, tx, bus, irq, sof, smp, rxb, fid;
  logic dom = 1'b0;
  logic exc = 1'b0;
  logic fend = 1'b0;
  logic chk = 1'b0;
  logic fd = 1'b1;
  logic ftx = 1'b1;
  logic [16:0] crc = 17'h00000;
  integer seed = 57;
  integer mismatches = 0;
  integer tests_run = 0;
  integer cycles = 0;
  integer n, k;
  time t0;

  // Short bit so the run stays brief: 2 clocks a quantum, 8 quanta a bit
  can_integ_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .can_rx_i(bus),
    .can_tx_o(tx), .exception_i(exc), .frame_end_i(fend), .frame_tx_i(ftx), .crc_check_i(chk),
    .crc_fd_i(fd), .crc_rx_i(crc), .irq_o(irq), .sof_o(sof), .sample_o(smp), .rx_bit_o(rxb));
  can_peer peer (.clk_i(clk_i), .rst_i(rst_i), .dut_tx_i(tx), .dom_i(dom), .bus_o(bus));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // ==================================================
  // Helpers
  function automatic integer bit_clocks(input integer p, input integer s1, input integer f);
    return (1 + s1 + f + 1) * (p + 1);
  endfunction

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Classic cycle; holds everything until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wait_smp(input integer cnt);
    repeat (cnt) begin
      @(posedge clk_i);
      while (smp !== 1'b1) @(posedge clk_i);
    end
  endtask

  task automatic wait_sof;
    n = 0;
    @(posedge clk_i);
    while (sof !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk_pin(sof, 1'b1);
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Release the hold, optionally spike mid-count, then watch the 11th sample
  task automatic integrate(input logic ef);
    wb(8'h00, 1'b1, 32'h1);
    wait_smp(1);
    wb(8'h00, 1'b1, {30'h0, ef, 1'b0});
    wait_smp(5);
    if (ef) begin
      dom <= 1'b1;
      repeat (2) @(posedge clk_i);
      dom <= 1'b0;
      n = 0;
      repeat (12) begin
        @(posedge clk_i);
        if (rxb !== 1'b1) n++;
      end
      chk_reg(n, 0);
    end
    wait_smp(5);
    wb(8'h08, 1'b0, 32'h0);
    chk_reg(q & 32'h7, 32'h1);
    wait_smp(1);
    wb(8'h08, 1'b0, 32'h0);
    chk_reg(q & 32'h7, 32'h2);
    wait_smp(1);
    t0 = $time;
    wait_smp(1);
    chk_reg(32'(($time - t0) / 5), 32'(bit_clocks(1, 4, 2)));
    end_test("integration");
  endtask

  // Hang guard; the whole run needs about a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      report_and_stop;
    end
  end

  // ==================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(8'h00, 1'b0, 32'h0);
    chk_reg(q, 32'h00000001);
    wb(8'h04, 1'b0, 32'h0);
    chk_reg(q, 32'h00070e03);
    wb(8'h10, 1'b0, 32'h0);
    chk_reg(q, 32'h0);
    wb(8'h40, 1'b1, 32'hffffffff);
    wb(8'h40, 1'b0, 32'h0);
    chk_reg(q, 32'h0);
    wb(8'h04, 1'b1, 32'h0000_0401);
    wb(8'h0c, 1'b0, 32'h0);
    chk_reg(q & 32'h10, 32'h10);
    wb(8'h04, 1'b1, TIM_VAL);
    wb(8'h10, 1'b1, 32'h1f);
    end_test("registers");
    integrate(1'b0);
    // Sticky status, mask and read-to-clear
    repeat (2) @(posedge clk_i);
    chk_pin(irq, 1'b1);
    wb(8'h10, 1'b1, 32'h0);
    repeat (2) @(posedge clk_i);
    chk_pin(irq, 1'b0);
    wb(8'h10, 1'b1, 32'h1f);
    wb(8'h0c, 1'b0, 32'h0);
    chk_reg(q, 32'h1);
    wb(8'h0c, 1'b0, 32'h0);
    chk_reg(q, 32'h0);
    repeat (2) @(posedge clk_i);
    chk_pin(irq, 1'b0);
    end_test("interrupt");
    integrate(1'b1);
    // Filter is off once idle, so a one-quantum spike now shows
    wait_smp(1);
    dom <= 1'b1;
    repeat (2) @(posedge clk_i);
    dom <= 1'b0;
    n = 0;
    repeat (10) begin
      @(posedge clk_i);
      if (rxb === 1'b0) n++;
    end
    chk_pin(n != 0, 1'b1);
    // Other node opens a frame; we queue a request and it hits intermission
    wait_smp(2);
    dom <= 1'b1;
    wait_sof();
    dom <= 1'b0;
    for (k = 0; k < 2; k++) begin
      fid = (k == 0) ? 1'b1 : 1'($random(seed));
      // Frame bits oppose the stored level so a wrong source shows; second pass is classical
      ftx <= ~fid;
      fd <= (k == 0);
      wait_smp(1);
      wb(8'h00, 1'b1, {27'h0, fid, 4'ha});
      fend <= 1'b1;
      @(posedge clk_i);
      fend <= 1'b0;
      wait_smp(2);
      dom <= 1'b1;
      wait_sof();
      dom <= 1'b0;
      crc <= 17'h10000;
      chk <= 1'b1;
      @(posedge clk_i);
      chk <= 1'b0;
      wait_smp(1);
      chk_pin(tx, fid);
      wb(8'h00, 1'b0, 32'h0);
      chk_reg(q, {27'h0, fid, 4'h2});
      wb(8'h0c, 1'b0, 32'h0);
      chk_reg(q & 32'h6, 32'h4);
    end
    end_test("intermission");
    ftx <= 1'b1;
    fd <= 1'b1;
    // Bad received check value drives an error flag
    crc <= 17'($random(seed));
    chk <= 1'b1;
    @(posedge clk_i);
    chk <= 1'b0;
    wait_smp(2);
    chk_pin(tx, 1'b0);
    wb(8'h0c, 1'b0, 32'h0);
    chk_reg(q & 32'h2, 32'h2);
    end_test("crc");
    wb(8'h00, 1'b1, 32'h2);
    exc <= 1'b1;
    @(posedge clk_i);
    exc <= 1'b0;
    wb(8'h08, 1'b0, 32'h0);
    chk_reg(q & 32'h7, 32'h1);
    // A full dominant bit while integrating restarts the idle count
    wait_smp(3);
    dom <= 1'b1;
    wait_smp(1);
    dom <= 1'b0;
    wb(8'h08, 1'b0, 32'h0);
    chk_reg(q & 32'hf07, 32'h1);
    wb(8'h00, 1'b1, 32'h6);
    exc <= 1'b1;
    @(posedge clk_i);
    exc <= 1'b0;
    wb(8'h08, 1'b0, 32'h0);
    chk_reg(q & 32'h7, 32'h5);
    end_test("exception");
    report_and_stop;
  end
endmodule
